//--- rtl/sad_pkg.sv
// Package: address map constants and target enumeration for the decoder
package sad_pkg;

  // Target select codes
  typedef enum logic [3:0] {
    SAD_TGT_NONE   = 4'b0000,
    SAD_TGT_FLASH  = 4'b0001,
    SAD_TGT_BROM   = 4'b0010,
    SAD_TGT_SRAML  = 4'b0011,
    SAD_TGT_SRAMU  = 4'b0100,
    SAD_TGT_PBRDG  = 4'b0101,
    SAD_TGT_USBRAM = 4'b0110,
    SAD_TGT_GPIO   = 4'b0111,
    SAD_TGT_BMA    = 4'b1000,
    SAD_TGT_PPB    = 4'b1001,
    SAD_TGT_TRCBUF = 4'b1010,
    SAD_TGT_TRCWP  = 4'b1011,
    SAD_TGT_ROMTBL = 4'b1100,
    SAD_TGT_MISC   = 4'b1101,
    SAD_TGT_SCGPIO = 4'b1110
  } sad_tgt_t;

  // Master identifiers
  localparam logic SAD_MST_CORE = 1'b0;
  localparam logic SAD_MST_DMA  = 1'b1;

  // Region bounds (inclusive)
  localparam logic [31:0] SAD_FLASH_LO  = 32'h0000_0000;
  localparam logic [31:0] SAD_FLASH_HI  = 32'h07ff_ffff;
  localparam logic [31:0] SAD_VEC_BYTES = 32'h0000_00c0;
  localparam logic [31:0] SAD_BROM_LO   = 32'h1c00_0000;
  localparam logic [31:0] SAD_BROM_HI   = 32'h1c00_3fff;
  localparam logic [31:0] SAD_SRAML_LO  = 32'h1fff_f000;
  localparam logic [31:0] SAD_SRAML_HI  = 32'h1fff_ffff;
  localparam logic [31:0] SAD_SRAMU_LO  = 32'h2000_0000;
  localparam logic [31:0] SAD_SRAMU_HI  = 32'h2000_2fff;
  localparam logic [31:0] SAD_PBRDG_LO  = 32'h4000_0000;
  localparam logic [31:0] SAD_PBRDG_HI  = 32'h4007_ffff;
  localparam logic [31:0] SAD_USB_LO    = 32'h400f_e000;
  localparam logic [31:0] SAD_USB_HI    = 32'h400f_e1ff;
  localparam logic [31:0] SAD_GPIO_LO   = 32'h400f_f000;
  localparam logic [31:0] SAD_GPIO_HI   = 32'h400f_ffff;
  localparam logic [31:0] SAD_BMA_LO    = 32'h4400_0000;
  localparam logic [31:0] SAD_BMA_HI    = 32'h5fff_ffff;
  localparam logic [31:0] SAD_PPB_LO    = 32'he000_0000;
  localparam logic [31:0] SAD_PPB_HI    = 32'he00f_ffff;
  localparam logic [31:0] SAD_TRCB_LO   = 32'hf000_0000;
  localparam logic [31:0] SAD_TRCB_HI   = 32'hf000_0fff;
  localparam logic [31:0] SAD_TRCW_LO   = 32'hf000_1000;
  localparam logic [31:0] SAD_TRCW_HI   = 32'hf000_1fff;
  localparam logic [31:0] SAD_ROMT_LO   = 32'hf000_2000;
  localparam logic [31:0] SAD_ROMT_HI   = 32'hf000_2fff;
  localparam logic [31:0] SAD_MISC_LO   = 32'hf000_3000;
  localparam logic [31:0] SAD_MISC_HI   = 32'hf000_3fff;
  localparam logic [31:0] SAD_SCG_LO    = 32'hf800_0000;
  localparam logic [31:0] SAD_SCG_HI    = 32'hffff_ffff;

  // Peripheral bridge slot layout
  localparam int          SAD_SLOTS      = 128;
  localparam int          SAD_SLOT_LSB   = 12;
  localparam logic [6:0]  SAD_SLOT_USB   = 7'h0e;
  localparam logic [6:0]  SAD_SLOT_GPIO  = 7'h0f;
  localparam logic [31:0] SAD_BMA_SLOT_M = 32'h000f_f000;

  // Default fitted sizes (bytes)
  localparam logic [31:0] SAD_FLASH_SIZE = 32'h0000_8000;
  localparam logic [31:0] SAD_SRAML_SIZE = 32'h0000_1000;
  localparam logic [31:0] SAD_SRAMU_SIZE = 32'h0000_3000;

endpackage : sad_pkg

//--- rtl/sad_slot_check.sv
// Peripheral bridge slot decode and enable check
`timescale 1ns/1ns
module sad_slot_check #(
  parameter int SLOTS = sad_pkg::SAD_SLOTS
) (
  // Access
  input  wire logic [31:0]      addr,
  // Slot enables
  input  wire logic [SLOTS-1:0] slot_impl,
  input  wire logic [SLOTS-1:0] slot_clk_en,
  // Result
  output logic [6:0]            slot_idx,
  output logic                  slot_ok
);

  logic [SLOTS-1:0] live;

  // ***********************************************
  // Live slot vector
  // ***********************************************
  genvar gi;
  generate
    for (gi = 0; gi < SLOTS; gi++) begin : g_live
      assign live[gi] = slot_impl[gi] & slot_clk_en[gi];
    end
  endgenerate

  // ***********************************************
  // Slot select
  // ***********************************************
  assign slot_idx = addr[sad_pkg::SAD_SLOT_LSB +: 7];
  assign slot_ok  = live[slot_idx];

endmodule : sad_slot_check

//--- rtl/sad_decoder.sv
// System address decoder: routes master accesses to targets
// Overview of operation
// - Every 32-bit address goes to exactly one target or is reserved.
// - 0x0000_0000 up to the fitted flash size selects program flash for all masters; the rest of 0x0000_0000-0x07FF_FFFF is refused.
// - First 192 bytes of flash hold vectors, served from flash.
// - Flash starts at zero; its limit follows the fitted flash size.
// - Lower and upper SRAM decoded for all masters, sized to fitted SRAM.
// - 0x400F_E000-0x400F_E1FF selects USB RAM, alias of bridge slot 14.
// - Bit-manipulation alias region maps bridge slots 0-127, core only.
// - Bit-manipulation alias also covers GPIO in bridge slot 15.
// - Trace buffer and trace watchpoint register ranges, core only.
// - Misc control register range 0xF000_3000-0xF000_3FFF, core only.
// - 0xF800_0000-0xFFFF_FFFF selects single-cycle GPIO port, core only.
// - Unimplemented or clock-disabled bridge slot ends with transfer error.
`timescale 1ns/1ns
module sad_decoder #(
  parameter logic [31:0] FLASH_SIZE = sad_pkg::SAD_FLASH_SIZE,
  parameter logic [31:0] SRAML_SIZE = sad_pkg::SAD_SRAML_SIZE,
  parameter logic [31:0] SRAMU_SIZE = sad_pkg::SAD_SRAMU_SIZE,
  parameter int          SLOTS      = sad_pkg::SAD_SLOTS
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             srst,
  // Master request
  input  wire logic             req_valid,
  input  wire logic             req_master,
  input  wire logic [31:0]      req_addr,
  // Bridge slot status
  input  wire logic [SLOTS-1:0] slot_impl,
  input  wire logic [SLOTS-1:0] slot_clk_en,
  // Decode result
  output logic                  rsp_valid,
  output sad_pkg::sad_tgt_t     rsp_target,
  output logic [31:0]           rsp_offset,
  output logic                  rsp_error,
  output logic                  rsp_vector
);

  sad_pkg::sad_tgt_t tgt_nxt;
  sad_pkg::sad_tgt_t tgt_r;
  logic              core_only;
  logic              err_nxt;
  logic [31:0]       off_nxt;
  logic [31:0]       slot_addr;
  logic [6:0]        slot_idx;
  logic              slot_ok;
  logic              valid_r;
  logic              err_r;
  logic              vec_r;
  logic [31:0]       off_r;

  function automatic logic in_rng(input logic [31:0] a,
                                  input logic [31:0] lo,
                                  input logic [31:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction : in_rng

  // ***********************************************
  // Slot address for bridge, alias and bit-manip
  // ***********************************************
  always_comb begin
    slot_addr = req_addr;
    if (in_rng(req_addr, sad_pkg::SAD_USB_LO, sad_pkg::SAD_USB_HI)) begin
      slot_addr = sad_pkg::SAD_PBRDG_LO
                | {13'h0000, sad_pkg::SAD_SLOT_USB, 12'h000}
                | (req_addr & 32'h0000_0fff);
    end else if (in_rng(req_addr, sad_pkg::SAD_GPIO_LO,
                        sad_pkg::SAD_GPIO_HI)) begin
      slot_addr = sad_pkg::SAD_PBRDG_LO
                | {13'h0000, sad_pkg::SAD_SLOT_GPIO, 12'h000}
                | (req_addr & 32'h0000_0fff);
    end else if (in_rng(req_addr, sad_pkg::SAD_BMA_LO,
                        sad_pkg::SAD_BMA_HI)) begin
      slot_addr = sad_pkg::SAD_PBRDG_LO
                | (req_addr & sad_pkg::SAD_BMA_SLOT_M)
                | (req_addr & 32'h0000_0fff);
    end
  end

  sad_slot_check #(
    .SLOTS       (SLOTS)
  ) u_slot (
    .addr        (slot_addr),
    .slot_impl   (slot_impl),
    .slot_clk_en (slot_clk_en),
    .slot_idx    (slot_idx),
    .slot_ok     (slot_ok)
  );

  // ***********************************************
  // Region decode
  // ***********************************************
  always_comb begin
    tgt_nxt   = sad_pkg::SAD_TGT_NONE;
    core_only = 1'b0;
    off_nxt   = 32'h0000_0000;
    if (in_rng(req_addr, sad_pkg::SAD_FLASH_LO,
               sad_pkg::SAD_FLASH_HI)) begin
      if (req_addr < FLASH_SIZE) begin
        tgt_nxt = sad_pkg::SAD_TGT_FLASH;
        off_nxt = req_addr - sad_pkg::SAD_FLASH_LO;
      end
    end else if (in_rng(req_addr, sad_pkg::SAD_BROM_LO,
                        sad_pkg::SAD_BROM_HI)) begin
      tgt_nxt   = sad_pkg::SAD_TGT_BROM;
      core_only = 1'b1;
      off_nxt   = req_addr - sad_pkg::SAD_BROM_LO;
    end else if (in_rng(req_addr, sad_pkg::SAD_SRAML_LO,
                        sad_pkg::SAD_SRAML_HI)) begin
      if (req_addr >= (sad_pkg::SAD_SRAMU_LO - SRAML_SIZE)) begin
        tgt_nxt = sad_pkg::SAD_TGT_SRAML;
        off_nxt = req_addr - (sad_pkg::SAD_SRAMU_LO - SRAML_SIZE);
      end
    end else if (in_rng(req_addr, sad_pkg::SAD_SRAMU_LO,
                        sad_pkg::SAD_SRAMU_HI)) begin
      if (req_addr < (sad_pkg::SAD_SRAMU_LO + SRAMU_SIZE)) begin
        tgt_nxt = sad_pkg::SAD_TGT_SRAMU;
        off_nxt = req_addr - sad_pkg::SAD_SRAMU_LO;
      end
    end else if (in_rng(req_addr, sad_pkg::SAD_PBRDG_LO,
                        sad_pkg::SAD_PBRDG_HI)) begin
      tgt_nxt = sad_pkg::SAD_TGT_PBRDG;
      off_nxt = req_addr - sad_pkg::SAD_PBRDG_LO;
    end else if (in_rng(req_addr, sad_pkg::SAD_USB_LO,
                        sad_pkg::SAD_USB_HI)) begin
      tgt_nxt = sad_pkg::SAD_TGT_USBRAM;
      off_nxt = slot_addr - sad_pkg::SAD_PBRDG_LO;
    end else if (in_rng(req_addr, sad_pkg::SAD_GPIO_LO,
                        sad_pkg::SAD_GPIO_HI)) begin
      tgt_nxt = sad_pkg::SAD_TGT_GPIO;
      off_nxt = slot_addr - sad_pkg::SAD_PBRDG_LO;
    end else if (in_rng(req_addr, sad_pkg::SAD_BMA_LO,
                        sad_pkg::SAD_BMA_HI)) begin
      tgt_nxt   = sad_pkg::SAD_TGT_BMA;
      core_only = 1'b1;
      off_nxt   = req_addr - sad_pkg::SAD_BMA_LO;
    end else if (in_rng(req_addr, sad_pkg::SAD_PPB_LO,
                        sad_pkg::SAD_PPB_HI)) begin
      tgt_nxt   = sad_pkg::SAD_TGT_PPB;
      core_only = 1'b1;
      off_nxt   = req_addr - sad_pkg::SAD_PPB_LO;
    end else if (in_rng(req_addr, sad_pkg::SAD_TRCB_LO,
                        sad_pkg::SAD_TRCB_HI)) begin
      tgt_nxt   = sad_pkg::SAD_TGT_TRCBUF;
      core_only = 1'b1;
      off_nxt   = req_addr - sad_pkg::SAD_TRCB_LO;
    end else if (in_rng(req_addr, sad_pkg::SAD_TRCW_LO,
                        sad_pkg::SAD_TRCW_HI)) begin
      tgt_nxt   = sad_pkg::SAD_TGT_TRCWP;
      core_only = 1'b1;
      off_nxt   = req_addr - sad_pkg::SAD_TRCW_LO;
    end else if (in_rng(req_addr, sad_pkg::SAD_ROMT_LO,
                        sad_pkg::SAD_ROMT_HI)) begin
      tgt_nxt   = sad_pkg::SAD_TGT_ROMTBL;
      core_only = 1'b1;
      off_nxt   = req_addr - sad_pkg::SAD_ROMT_LO;
    end else if (in_rng(req_addr, sad_pkg::SAD_MISC_LO,
                        sad_pkg::SAD_MISC_HI)) begin
      tgt_nxt   = sad_pkg::SAD_TGT_MISC;
      core_only = 1'b1;
      off_nxt   = req_addr - sad_pkg::SAD_MISC_LO;
    end else if (in_rng(req_addr, sad_pkg::SAD_SCG_LO,
                        sad_pkg::SAD_SCG_HI)) begin
      tgt_nxt   = sad_pkg::SAD_TGT_SCGPIO;
      core_only = 1'b1;
      off_nxt   = req_addr - sad_pkg::SAD_SCG_LO;
    end
  end

  // ***********************************************
  // Error decision
  // ***********************************************
  always_comb begin
    err_nxt = 1'b0;
    if (tgt_nxt == sad_pkg::SAD_TGT_NONE) begin
      err_nxt = 1'b1;
    end else if (core_only && (req_master != sad_pkg::SAD_MST_CORE)) begin
      err_nxt = 1'b1;
    end else begin
      case (tgt_nxt)
        sad_pkg::SAD_TGT_PBRDG,
        sad_pkg::SAD_TGT_USBRAM,
        sad_pkg::SAD_TGT_GPIO,
        sad_pkg::SAD_TGT_BMA: begin
          err_nxt = !slot_ok;
        end
        default: begin
          err_nxt = 1'b0;
        end
      endcase
    end
  end

  // ***********************************************
  // Response registers
  // ***********************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      valid_r <= 1'b0;
    end else begin
      valid_r <= req_valid;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tgt_r <= sad_pkg::SAD_TGT_NONE;
      err_r <= 1'b0;
      vec_r <= 1'b0;
      off_r <= 32'h0000_0000;
    end else if (req_valid) begin
      tgt_r <= err_nxt ? sad_pkg::SAD_TGT_NONE : tgt_nxt;
      err_r <= err_nxt;
      vec_r <= !err_nxt && (tgt_nxt == sad_pkg::SAD_TGT_FLASH)
               && (req_addr < sad_pkg::SAD_VEC_BYTES);
      off_r <= err_nxt ? 32'h0000_0000 : off_nxt;
    end
  end

  assign rsp_valid  = valid_r;
  assign rsp_target = tgt_r;
  assign rsp_offset = off_r;
  assign rsp_error  = err_r;
  assign rsp_vector = vec_r;

endmodule : sad_decoder

//--- tb/sad_mst_model.sv
// Bus master model issuing one-cycle decode requests
`timescale 1ns/1ns
module sad_mst_model (
  // Clock
  input  wire logic   clk_sys,
  // Request
  output logic        req_valid,
  output logic        req_master,
  output logic [31:0] req_addr
);
  // ****
  // Drive
  // ****
  initial begin
    req_valid  = 1'b0;
    req_master = 1'b0;
    req_addr   = 32'h0000_0000;
  end
  task automatic issue(input logic m, input logic [31:0] a);
    @(posedge clk_sys);
    #1;
    req_valid  = 1'b1;
    req_master = m;
    req_addr   = a;
  endtask : issue
  // Released lines show the inverse of the last value
  task automatic idle();
    @(posedge clk_sys);
    #1;
    req_valid  = 1'b0;
    req_master = ~req_master;
    req_addr   = ~req_addr;
  endtask : idle
endmodule : sad_mst_model

//--- tb/sad_decoder_chk.sv
// Checker: decode timing and map relations at the decoder ports
`timescale 1ns/1ns
module sad_chk #(
  parameter logic [31:0] FLASH_SIZE = 32'h0000_8000,
  parameter logic [31:0] SRAMU_SIZE = 32'h0000_3000,
  parameter int          SLOTS      = 128
) (
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              srst,
  // Request
  input wire logic              req_valid,
  input wire logic              req_master,
  input wire logic [31:0]       req_addr,
  input wire logic [SLOTS-1:0]  slot_impl,
  input wire logic [SLOTS-1:0]  slot_clk_en,
  // Response
  input wire logic              rsp_valid,
  input wire sad_pkg::sad_tgt_t rsp_target,
  input wire logic [31:0]       rsp_offset,
  input wire logic              rsp_error,
  input wire logic              rsp_vector
);
  // ****
  // Checks
  // ****
  logic       slot_on;
  logic       brdg;
  logic       bma;
  assign slot_on = slot_impl[req_addr[18:12]] & slot_clk_en[req_addr[18:12]];
  assign brdg    = req_addr[31:19] == 13'h0800;
  assign bma     = req_addr >= 32'h4400_0000 && req_addr <= 32'h5fff_ffff;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_answer_next: assert property (req_valid |=> rsp_valid)
    else $error("request not answered next cycle");
  a_no_extra: assert property (!req_valid |=> !rsp_valid)
    else $error("response without request");
  a_hold_result: assert property (!req_valid |=> $stable(rsp_target))
    else $error("target changed without request");
  a_flash_hit: assert property (req_valid && req_addr < FLASH_SIZE
    |=> rsp_target == sad_pkg::SAD_TGT_FLASH && !rsp_error
        && rsp_offset == $past(req_addr))
    else $error("flash access misrouted");
  a_vector_fetch: assert property (req_valid && req_addr < 32'h0000_00c0
    |=> rsp_vector && rsp_target == sad_pkg::SAD_TGT_FLASH)
    else $error("vector fetch not flagged");
  a_flash_limit: assert property (req_valid && req_addr >= FLASH_SIZE
    && req_addr <= 32'h07ff_ffff |=> rsp_error)
    else $error("flash beyond fitted size not refused");
  a_sramu_hit: assert property (req_valid
    && req_addr[31:16] == 16'h2000 && req_addr[15:0] < SRAMU_SIZE
    |=> rsp_target == sad_pkg::SAD_TGT_SRAMU && !rsp_error)
    else $error("upper sram misrouted");
  a_dma_alias: assert property (req_valid && req_master && bma
    |=> rsp_error)
    else $error("dma reached bit alias");
  a_dma_high: assert property (req_valid && req_master
    && req_addr >= 32'hf000_0000 |=> rsp_error)
    else $error("dma reached core only region");
  a_slot_off: assert property (req_valid && (brdg || bma)
    && !slot_on |=> rsp_error)
    else $error("disabled slot not refused");
  a_error_form: assert property (rsp_valid && rsp_error
    |-> rsp_target == sad_pkg::SAD_TGT_NONE && rsp_offset == 32'h0)
    else $error("error response carries target");
endmodule : sad_chk
bind sad_decoder sad_chk #(
  .FLASH_SIZE(FLASH_SIZE), .SRAMU_SIZE(SRAMU_SIZE), .SLOTS(SLOTS)
) u_chk (
  .clk_sys(clk_sys), .srst(srst), .req_valid(req_valid),
  .req_master(req_master), .req_addr(req_addr), .slot_impl(slot_impl),
  .slot_clk_en(slot_clk_en), .rsp_valid(rsp_valid),
  .rsp_target(rsp_target), .rsp_offset(rsp_offset),
  .rsp_error(rsp_error), .rsp_vector(rsp_vector)
);

//--- tb/tb_system_address_decoder.sv
// Testbench: directed decode scenarios against the address map
`timescale 1ns/1ns
module tb_system_address_decoder;
  // ****
  // Bench
  // ****
  logic              clk_sys;
  logic              srst;
  logic              req_valid;
  logic              req_master;
  logic [31:0]       req_addr;
  logic [127:0]      slot_impl;
  logic [127:0]      slot_clk_en;
  logic              rsp_valid;
  sad_pkg::sad_tgt_t rsp_target;
  logic [31:0]       rsp_offset;
  logic              rsp_error;
  logic              rsp_vector;
  int                err_count;
  int                n_compared;
  sad_mst_model u_mst (.clk_sys(clk_sys), .req_valid(req_valid),
    .req_master(req_master), .req_addr(req_addr));
  sad_decoder DUT (.clk_sys(clk_sys), .srst(srst), .req_valid(req_valid),
    .req_master(req_master), .req_addr(req_addr), .slot_impl(slot_impl),
    .slot_clk_en(slot_clk_en), .rsp_valid(rsp_valid),
    .rsp_target(rsp_target), .rsp_offset(rsp_offset),
    .rsp_error(rsp_error), .rsp_vector(rsp_vector));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [38:0] g, input logic [38:0] x);
    n_compared++;
    if (g !== x) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  task automatic look(input logic [31:0] o, input sad_pkg::sad_tgt_t t,
                      input logic e, input logic v);
    chk({rsp_valid, rsp_error, rsp_vector, rsp_target, rsp_offset},
        {1'b1, e, v, t, o});
  endtask : look
  task automatic acc(input logic m, input logic [31:0] a,
                     input sad_pkg::sad_tgt_t t, input logic [31:0] o,
                     input logic v);
    u_mst.issue(m, a);
    u_mst.idle();
    look(o, t, 1'b0, v);
  endtask : acc
  task automatic err(input logic m, input logic [31:0] a);
    u_mst.issue(m, a);
    u_mst.idle();
    look(32'h0, sad_pkg::SAD_TGT_NONE, 1'b1, 1'b0);
  endtask : err
  task automatic t_flash();
    acc(1'b0, 32'h0000_0004, sad_pkg::SAD_TGT_FLASH, 32'h4, 1'b1);
    acc(1'b1, 32'h0000_00bc, sad_pkg::SAD_TGT_FLASH, 32'hbc, 1'b1);
    acc(1'b1, 32'h0000_00c0, sad_pkg::SAD_TGT_FLASH, 32'hc0, 1'b0);
    acc(1'b0, 32'h0000_7ffc, sad_pkg::SAD_TGT_FLASH, 32'h7ffc, 1'b0);
    err(1'b0, 32'h0000_8000);
    $display("test flash done");
  endtask : t_flash
  task automatic t_sram();
    acc(1'b1, 32'h1fff_f000, sad_pkg::SAD_TGT_SRAML, 32'h0, 1'b0);
    acc(1'b1, 32'h2000_2fff, sad_pkg::SAD_TGT_SRAMU, 32'h2fff, 1'b0);
    err(1'b0, 32'h2000_3000);
    $display("test sram done");
  endtask : t_sram
  task automatic t_alias();
    acc(1'b1, 32'h400f_e010, sad_pkg::SAD_TGT_USBRAM, 32'he010, 1'b0);
    acc(1'b0, 32'h4400_f004, sad_pkg::SAD_TGT_BMA, 32'hf004, 1'b0);
    acc(1'b1, 32'h400f_f020, sad_pkg::SAD_TGT_GPIO, 32'hf020, 1'b0);
    err(1'b1, 32'h4400_f004);
    slot_clk_en[15] = 1'b0;
    err(1'b0, 32'h4400_f004);
    err(1'b1, 32'h400f_f020);
    slot_clk_en[15] = 1'b1;
    $display("test alias done");
  endtask : t_alias
  task automatic t_slot();
    acc(1'b1, 32'h4000_8010, sad_pkg::SAD_TGT_PBRDG, 32'h8010, 1'b0);
    slot_clk_en[8] = 1'b0;
    err(1'b1, 32'h4000_8010);
    slot_clk_en[8] = 1'b1;
    slot_impl[8] = 1'b0;
    err(1'b0, 32'h4000_8010);
    slot_impl[8] = 1'b1;
    $display("test slot done");
  endtask : t_slot
  task automatic t_core_only();
    logic [31:0]       ad [7] = '{32'hf000_0000, 32'hf000_1ffc,
                                  32'hf000_3000, 32'hf800_0010,
                                  32'h1c00_0100, 32'he000_e010,
                                  32'hf000_2004};
    logic [31:0]       of [7] = '{32'h0, 32'hffc, 32'h0, 32'h10,
                                  32'h100, 32'he010, 32'h4};
    sad_pkg::sad_tgt_t tg [7] = '{sad_pkg::SAD_TGT_TRCBUF,
      sad_pkg::SAD_TGT_TRCWP, sad_pkg::SAD_TGT_MISC, sad_pkg::SAD_TGT_SCGPIO,
      sad_pkg::SAD_TGT_BROM, sad_pkg::SAD_TGT_PPB, sad_pkg::SAD_TGT_ROMTBL};
    for (int i = 0; i < 7; i++) begin
      acc(1'b0, ad[i], tg[i], of[i], 1'b0);
      err(1'b1, ad[i]);
    end
    $display("test core only done");
  endtask : t_core_only
  task automatic t_reserved();
    logic [31:0] ad [5] = '{32'h0800_0000, 32'h1c00_4000, 32'h400f_e200,
                            32'h6000_0000, 32'hf000_4000};
    for (int i = 0; i < 5; i++) begin
      err(1'b0, ad[i]);
    end
    $display("test reserved done");
  endtask : t_reserved
  task automatic t_b2b();
    u_mst.issue(1'b0, 32'h0000_0008);
    u_mst.issue(1'b1, 32'h2000_0010);
    look(32'h8, sad_pkg::SAD_TGT_FLASH, 1'b0, 1'b1);
    u_mst.idle();
    look(32'h10, sad_pkg::SAD_TGT_SRAMU, 1'b0, 1'b0);
    $display("test back to back done");
  endtask : t_b2b
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  initial begin
    #20000;
    err_count++;
    stop_test();
  end
  initial begin
    err_count   = 0;
    n_compared  = 0;
    srst        = 1'b1;
    slot_impl   = '1;
    slot_clk_en = '1;
    repeat (20) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    t_flash();
    t_sram();
    t_alias();
    t_slot();
    t_core_only();
    t_reserved();
    t_b2b();
    stop_test();
  end
endmodule : tb_system_address_decoder
